/* shared/gps_params.svh */
`ifndef GPS_PARAMS_SVH
`define GPS_PARAMS_SVH

// Register byte offsets
`define GPS_OFS_DIR       8'h00
`define GPS_OFS_DRIVE     8'h04
`define GPS_OFS_INPUT     8'h08
`define GPS_OFS_RESET     8'h0C
`define GPS_OFS_POWER     8'h10
`define GPS_OFS_STATUS    8'h14

// Field positions in the status word
`define GPS_STAT_BUSY     0
`define GPS_STAT_ARMED    1
`define GPS_STAT_VIOL     2

// Reset values and keys
`define GPS_DIR_RST       12'h000
`define GPS_DRIVE_RST     12'h000
`define GPS_POWER_RST     16'h0000
`define GPS_RESET_KEY     16'h6600

// Timing: hold-off time in microseconds and core clock rate in MHz
`define GPS_HOLD_US       200
`define GPS_CLK_MHZ       100

// Bus responses
`define GPS_RESP_OKAY     2'h0
`define GPS_RESP_SLVERR   2'h2

`endif

/* shared/gps_pkg.sv */
package gps_pkg;

    // Pin configuration carried as one unit
    typedef struct packed {
        logic [11:0] dir;
        logic [11:0] drive;
    } gps_gpio_cfg_t;

    // Read answer carried as one unit
    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } gps_rd_t;

    // Start-up and soft-reset sequencing
    typedef enum logic [1:0] {
        GPS_ST_HOLD  = 2'b00,
        GPS_ST_RUN   = 2'b01,
        GPS_ST_ARMED = 2'b10
    } gps_state_t;

endpackage

/* hw/gps_sync2.sv */
`timescale 1ns/100ps
// Two-stage synchroniser; the first stage feeds only the second
module gps_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Both stages freeze with the clock enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* hw/gps_gpio_top.sv */
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "gps_params.svh"
// Behaviour
// - Direction bit 1 drives the pin with its drive-value bit.
// - Direction bit 0 floats the pin and captures its level as input.
// - Drive-value writes never change a pin configured as input.
// - After any reset all twelve pins are inputs, high impedance.
// - No access accepted for 200 us after power-up; host waits too. Status reads still answer OKAY then.
// - Writing key 0x6600 to the reset word starts a software reset.
// - Access returns 200 us after chip-select rise closing the reset frame.
// - Power-up returns every register to its default; software reset does so for all but the input register, which keeps sampling the pins.
// - Analog power-control default leaves every analog block off.
module gps_gpio_top
    import gps_pkg::*;
#(
    parameter int NPINS       = 12,
    parameter int HOLD_CYCLES = `GPS_HOLD_US * `GPS_CLK_MHZ
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // AXI4-Lite slave
    input  wire logic [7:0]       s_awaddr,
    input  wire logic             s_awvalid,
    output logic                  s_awready,
    input  wire logic [31:0]      s_wdata,
    input  wire logic [3:0]       s_wstrb,
    input  wire logic             s_wvalid,
    output logic                  s_wready,
    output logic [1:0]            s_bresp,
    output logic                  s_bvalid,
    input  wire logic             s_bready,
    input  wire logic [7:0]       s_araddr,
    input  wire logic             s_arvalid,
    output logic                  s_arready,
    output logic [31:0]           s_rdata,
    output logic [1:0]            s_rresp,
    output logic                  s_rvalid,
    input  wire logic             s_rready,
    // Serial link pins, sampled by the core clock
    input  wire logic             ser_clk,
    input  wire logic             ser_cs_n,
    // GPIO pins
    input  wire logic [NPINS-1:0] gpio_i,
    output logic      [NPINS-1:0] gpio_o,
    output logic      [NPINS-1:0] gpio_oe,
    // Analog power-control word
    output logic [15:0]           analog_pwr
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and the link

    logic [NPINS+1:0] sync_all;
    logic [NPINS-1:0] pin_sync;
    logic             clk_s;
    logic             cs_s;
    logic             clk_d;
    logic             cs_d;

    gps_sync2 #(.WIDTH(NPINS + 2)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .async_in ({~ser_cs_n, ser_clk, gpio_i}),
        .sync_out (sync_all)
    );

    // Split the synchronised bus
    assign pin_sync = sync_all[NPINS-1:0];
    assign clk_s    = sync_all[NPINS];
    assign cs_s     = ~sync_all[NPINS+1]; // Inverted so reset reads as idle, no false rise

    // Edge history, taken from the second stage only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_d <= 1'b0;
            cs_d  <= 1'b1;
        end else if (ce) begin
            clk_d <= clk_s;
            cs_d  <= cs_s;
        end
    end
    logic cs_rise;
    logic sclk_rise;
    assign cs_rise   = cs_s & ~cs_d;
    assign sclk_rise = clk_s & ~clk_d & ~cs_s;

    ////////////////////////////////////////////////////////////////////////////
    // Bus channel capture

    gps_state_t    state;
    gps_state_t    next_state;
    logic [CW-1:0] hold_cnt;
    logic          busy;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    aw_q;
    logic [31:0]   w_q;
    logic [3:0]    ws_q;

    // Readies stall while frozen or while a response waits
    assign s_awready = ce & ~aw_got & ~s_bvalid;
    assign s_wready  = ce & ~w_got & ~s_bvalid;
    assign s_arready = ce & ~s_rvalid;

    logic        aw_have;
    logic        w_have;
    logic        wr_do;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  wsb;
    logic [15:0] wmask;
    assign aw_have = aw_got | (s_awvalid & s_awready);
    assign w_have  = w_got | (s_wvalid & s_wready);
    assign wr_do   = ce & aw_have & w_have & ~s_bvalid;
    assign wa      = aw_got ? aw_q : s_awaddr;
    assign wd      = w_got ? w_q : s_wdata;
    assign wsb     = w_got ? ws_q : s_wstrb;
    assign wmask   = {{8{wsb[1]}}, {8{wsb[0]}}};

    // Hold whichever half of a write arrives first
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            aw_q   <= 8'h00;
            w_q    <= 32'h0;
            ws_q   <= 4'h0;
        end else if (ce) begin
            aw_got <= aw_have & ~wr_do;
            w_got  <= w_have & ~wr_do;
            if (s_awvalid && s_awready) aw_q <= s_awaddr;
            if (s_wvalid && s_wready) begin
                w_q  <= s_wdata;
                ws_q <= s_wstrb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic sel_dir;
    logic sel_drv;
    logic sel_rst;
    logic sel_pwr;
    logic sel_stat;
    logic wr_known;
    logic wr_ok;
    logic key_hit;
    logic sw_apply;
    assign sel_dir  = (wa == `GPS_OFS_DIR);
    assign sel_drv  = (wa == `GPS_OFS_DRIVE);
    assign sel_rst  = (wa == `GPS_OFS_RESET);
    assign sel_pwr  = (wa == `GPS_OFS_POWER);
    assign sel_stat = (wa == `GPS_OFS_STATUS);
    assign wr_known = sel_dir | sel_drv | sel_rst | sel_pwr | sel_stat
                      | (wa == `GPS_OFS_INPUT);
    // Nothing is written while the hold-off runs
    assign wr_ok    = wr_do & wr_known & ~busy;
    assign key_hit  = wr_ok & sel_rst & (wsb[1:0] == 2'b11)
                      & (wd[15:0] == `GPS_RESET_KEY);
    assign sw_apply = (state == GPS_ST_ARMED) & cs_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    gps_gpio_cfg_t cfg;
    logic [11:0]   next_dir;
    logic [11:0]   next_drive;
    logic [15:0]   next_pwr;
    logic          viol;
    assign next_dir   = (cfg.dir & ~wmask[11:0]) | (wd[11:0] & wmask[11:0]);
    assign next_drive = (cfg.drive & ~wmask[11:0]) | (wd[11:0] & wmask[11:0]);
    assign next_pwr   = (analog_pwr & ~wmask) | (wd[15:0] & wmask);

    // Software reset reloads the same defaults as the pin reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg.dir    <= `GPS_DIR_RST;
            cfg.drive  <= `GPS_DRIVE_RST;
            analog_pwr <= `GPS_POWER_RST;
        end else if (ce) begin
            if (sw_apply) begin
                cfg.dir    <= `GPS_DIR_RST;
                cfg.drive  <= `GPS_DRIVE_RST;
                analog_pwr <= `GPS_POWER_RST;
            end else if (wr_ok) begin
                if (sel_dir) cfg.dir <= next_dir;
                if (sel_drv) cfg.drive <= next_drive;
                if (sel_pwr) analog_pwr <= next_pwr;
            end
        end
    end

    // Host clocking the link during a hold-off; sticky, write 1 to clear, set wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            viol <= 1'b0;
        end else if (ce) begin
            if (busy && sclk_rise) begin
                viol <= 1'b1;
            end else if (sw_apply || (wr_ok && sel_stat && wsb[0] && wd[`GPS_STAT_VIOL])) begin
                viol <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins

    logic [NPINS-1:0] in_reg;
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            // Inputs track the synchronised level; outputs keep the last sample
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    in_reg[gi] <= 1'b0;
                end else if (ce && !cfg.dir[gi]) begin
                    in_reg[gi] <= pin_sync[gi];
                end
            end
            assign gpio_oe[gi] = cfg.dir[gi];
            assign gpio_o[gi]  = cfg.drive[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Start-up and soft-reset sequencing

    // The armed reset waits for the frame to close, so the key write itself completes
    always_comb begin
        next_state = state;
        unique case (state)
            GPS_ST_HOLD:  if (hold_cnt == '0) next_state = GPS_ST_RUN;
            GPS_ST_RUN:   if (key_hit) next_state = GPS_ST_ARMED;
            GPS_ST_ARMED: if (cs_rise) next_state = GPS_ST_HOLD;
            default:      next_state = GPS_ST_HOLD;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state    <= GPS_ST_HOLD;
            hold_cnt <= CW'(HOLD_CYCLES - 1);
        end else if (ce) begin
            state <= next_state;
            if (sw_apply) hold_cnt <= CW'(HOLD_CYCLES - 1);
            else if (state == GPS_ST_HOLD && hold_cnt != '0) hold_cnt <= hold_cnt - 1'b1;
        end
    end
    assign busy = (state == GPS_ST_HOLD);

    ////////////////////////////////////////////////////////////////////////////
    // Responses

    logic    rd_stat;
    logic    rd_known;
    gps_rd_t rd_next;
    logic [31:0] stat_word;
    assign stat_word = {29'h0, viol, (state == GPS_ST_ARMED), busy};
    assign rd_stat   = (s_araddr == `GPS_OFS_STATUS);
    assign rd_known  = rd_stat | (s_araddr == `GPS_OFS_DIR) | (s_araddr == `GPS_OFS_DRIVE)
                       | (s_araddr == `GPS_OFS_INPUT) | (s_araddr == `GPS_OFS_RESET)
                       | (s_araddr == `GPS_OFS_POWER);

    // Read mux; only status answers during a hold-off so software can poll
    always_comb begin
        rd_next.resp = `GPS_RESP_OKAY;
        unique case (s_araddr)
            `GPS_OFS_DIR:    rd_next.data = {20'h0, cfg.dir};
            `GPS_OFS_DRIVE:  rd_next.data = {20'h0, cfg.drive};
            `GPS_OFS_INPUT:  rd_next.data = {20'h0, in_reg};
            `GPS_OFS_POWER:  rd_next.data = {16'h0, analog_pwr};
            `GPS_OFS_STATUS: rd_next.data = stat_word;
            default:         rd_next.data = 32'h0;
        endcase
        if (!rd_known || (busy && !rd_stat)) begin
            rd_next.resp = `GPS_RESP_SLVERR;
            rd_next.data = 32'h0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `GPS_RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= `GPS_RESP_OKAY;
        end else if (ce) begin
            if (wr_do) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? `GPS_RESP_OKAY : `GPS_RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_next.data;
                s_rresp  <= rd_next.resp;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_dir_drives_oe: assert property (wr_ok && sel_dir && !sw_apply
        |=> gpio_oe == $past(next_dir)) else $error("direction write not reflected");
    chk_drive_on_pin: assert property (wr_ok && sel_drv && !sw_apply
        |=> gpio_o == $past(next_drive)) else $error("drive value not on pin");
    chk_input_capture: assert property (ce && !gpio_oe[0]
        |=> in_reg[0] == $past(pin_sync[0])) else $error("input level not captured");
    chk_input_stays_quiet: assert property (wr_ok && sel_drv && !sw_apply
        |=> $stable(gpio_oe)) else $error("drive write moved enables");
    chk_soft_defaults: assert property (ce && sw_apply
        |=> (gpio_oe | gpio_o) == '0 && analog_pwr == '0) else $error("defaults not restored");
    chk_holdoff_refuse: assert property (s_arvalid && s_arready && busy && !rd_stat
        |=> s_rvalid && s_rresp == `GPS_RESP_SLVERR) else $error("access accepted in hold-off");
    chk_key_arms: assert property (ce && key_hit && !sw_apply
        |=> state == GPS_ST_ARMED) else $error("key did not arm reset");
    chk_holdoff_length: assert property (ce && sw_apply
        |=> busy [*8]) else $error("hold-off ended early");
    chk_bad_key_ignored: assert property (wr_ok && sel_rst && !key_hit && !sw_apply
        |=> state == $past(state) && $stable(gpio_oe)) else $error("bad key changed state");
    cov_soft_reset: cover property (sw_apply ##1 busy);
    cov_pin_driven: cover property (wr_ok && sel_dir ##1 gpio_oe != '0);
    cov_holdoff_done: cover property (busy ##1 !busy);
endmodule

/* sim/gps_host_model.sv */
`timescale 1ns/100ps
// Host side of the serial link: frames chip-select around eight link clocks
module gps_host_model #(
    parameter int HOLD = 16
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic frame_req,
    output logic      ser_clk,
    output logic      ser_cs_n,
    output logic      link_ok
);
    int wait_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // Hold-off after reset and after every frame; a margin covers the pin synchroniser
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= HOLD + 4;
        end else if (!ser_cs_n) begin
            wait_cnt <= HOLD + 4;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
    assign link_ok = (wait_cnt == 0);

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock stands low outside frames; offset keeps it off the core edges
    initial begin
        ser_clk  = 1'b0;
        ser_cs_n = 1'b1;
        forever begin
            @(posedge core_clk iff (frame_req && link_ok));
            #3 ser_cs_n = 1'b0;
            repeat (8) begin
                #40 ser_clk = 1'b1;
                #40 ser_clk = 1'b0;
            end
            #40 ser_cs_n = 1'b1;
        end
    end
endmodule

/* sim/test_gpio_port_soft_reset.sv */
`timescale 1ns/100ps
`include "gps_params.svh"
// Bench: bus master, pad wiring and soft-reset flow
module test_gpio_port_soft_reset;
    localparam int HOLD = 16;
    logic        core_clk, rst, ce, frame_req, link_ok, ser_clk, ser_cs_n;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp;
    logic [11:0] ext, gpio_o, gpio_oe;
    logic [15:0] analog_pwr;
    wire  [11:0] pad;
    int          fails, checks_done;

    // Pad level: driven pins show the drive bit, floating pins the outside level
    assign pad = (gpio_oe & gpio_o) | (~gpio_oe & ext);

    gps_gpio_top #(.HOLD_CYCLES(HOLD)) i_dut (
        .core_clk(core_clk), .rst(rst), .ce(ce), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .gpio_i(pad), .gpio_o(gpio_o),
        .gpio_oe(gpio_oe), .analog_pwr(analog_pwr));

    gps_host_model #(.HOLD(HOLD)) i_host (
        .core_clk(core_clk), .rst(rst), .frame_req(frame_req), .ser_clk(ser_clk),
        .ser_cs_n(ser_cs_n), .link_ok(link_ok));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the whole flow needs well under a thousand cycles
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        fails++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Channels released one by one as each is taken; waits until the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge core_clk);
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        chk(s_rdata, ed);
        chk({30'h0, s_rresp}, {30'h0, er});
    endtask

    task automatic wait_link();
        int n;
        n = 0;
        while (link_ok !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, link_ok}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_power_up();
        chk({20'h0, gpio_oe}, 32'h0);
        chk({16'h0, analog_pwr}, 32'h0);
        wr(`GPS_OFS_DIR, 32'hFFF, `GPS_RESP_SLVERR);
        chk({20'h0, gpio_oe}, 32'h0);
        rd(`GPS_OFS_STATUS, 32'h1 << `GPS_STAT_BUSY, `GPS_RESP_OKAY);
        wait_link();
        rd(`GPS_OFS_STATUS, 32'h0, `GPS_RESP_OKAY);
    endtask

    task automatic t_pins();
        wr(`GPS_OFS_DIR, 32'h0F0, `GPS_RESP_OKAY);
        wr(`GPS_OFS_DRIVE, 32'hFFF, `GPS_RESP_OKAY);
        chk({20'h0, gpio_oe}, 32'h0F0);
        chk({20'h0, pad}, {20'h0, 12'h0F0 | (12'hABC & 12'hF0F)});
        rd(`GPS_OFS_INPUT, 32'hABC, `GPS_RESP_OKAY);
        ext <= 12'h543;
        rd(`GPS_OFS_INPUT, 32'hABC, `GPS_RESP_OKAY);
        repeat (4) @(posedge core_clk);
        rd(`GPS_OFS_INPUT, 32'h5B3, `GPS_RESP_OKAY);
        wr(`GPS_OFS_DRIVE, 32'h000, `GPS_RESP_OKAY);
        chk({20'h0, pad}, 32'h503);
        chk({20'h0, gpio_oe}, 32'h0F0);
    endtask

    // Clock enable low freezes the synchroniser, so a pin change made then stays unseen
    task automatic t_freeze();
        @(posedge core_clk);
        ce  <= 1'b0;
        ext <= 12'hFFF;
        repeat (6) @(posedge core_clk);
        ce <= 1'b1;
        rd(`GPS_OFS_INPUT, 32'h5B3, `GPS_RESP_OKAY);
        repeat (4) @(posedge core_clk);
        rd(`GPS_OFS_INPUT, 32'hFBF, `GPS_RESP_OKAY);
    endtask

    task automatic t_soft_reset();
        wr(`GPS_OFS_POWER, 32'h1234, `GPS_RESP_OKAY);
        chk({16'h0, analog_pwr}, 32'h1234);
        wr(`GPS_OFS_RESET, 32'h1234, `GPS_RESP_OKAY);
        rd(`GPS_OFS_STATUS, 32'h0, `GPS_RESP_OKAY);
        chk({20'h0, gpio_oe}, 32'h0F0);
        wr(`GPS_OFS_RESET, {16'h0, `GPS_RESET_KEY}, `GPS_RESP_OKAY);
        rd(`GPS_OFS_STATUS, 32'h1 << `GPS_STAT_ARMED, `GPS_RESP_OKAY);
        // The reset lands only at the chip-select rise that closes the frame
        frame_req <= 1'b1;
        @(negedge ser_cs_n);
        frame_req <= 1'b0;
        @(posedge ser_cs_n);
        repeat (6) @(posedge core_clk);
        chk({20'h0, gpio_oe}, 32'h0);
        chk({16'h0, analog_pwr}, 32'h0);
        wr(`GPS_OFS_DIR, 32'hFFF, `GPS_RESP_SLVERR);
        wait_link();
        rd(`GPS_OFS_DIR, 32'h0, `GPS_RESP_OKAY);
        rd(`GPS_OFS_DRIVE, 32'h0, `GPS_RESP_OKAY);
        rd(`GPS_OFS_POWER, 32'h0, `GPS_RESP_OKAY);
        rd(8'h20, 32'h0, `GPS_RESP_SLVERR);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1; ce = 1'b1; frame_req = 1'b0; ext = 12'hABC;
        s_awaddr = 8'h00; s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'hF;
        s_wvalid = 1'b0; s_bready = 1'b0; s_araddr = 8'h00; s_arvalid = 1'b0;
        s_rready = 1'b0; fails = 0; checks_done = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_power_up();
        t_pins();
        t_freeze();
        t_soft_reset();
        close_out();
    end
endmodule
